//--- rtl/drc_map.svh
// drive run-command / frequency control: parameter indices, defaults, codes, timing
// assumes a 10 MHz system clock; frequencies in 0.01 Hz, voltages in 0.1 V, times in 0.1 s
`ifndef DRC_MAP_SVH
`define DRC_MAP_SVH
// parameter indices
`define DRC_ID_SETPOINT     5'h00
`define DRC_ID_FREQ_SRC     5'h01
`define DRC_ID_RUN_SRC      5'h02
`define DRC_ID_STOP_LOCK    5'h03
`define DRC_ID_REV_PREVENT  5'h04
`define DRC_ID_MAX_FREQ     5'h05
`define DRC_ID_MIN_FREQ     5'h06
`define DRC_ID_ACCEL        5'h07
`define DRC_ID_DECEL        5'h08
`define DRC_ID_VF_MAX_V     5'h09
`define DRC_ID_VF_BASE_F    5'h0A
`define DRC_ID_VF_MID_V     5'h0B
`define DRC_ID_VF_MID_F     5'h0C
`define DRC_ID_VF_MIN_V     5'h0D
`define DRC_ID_VF_MIN_F     5'h0E
`define DRC_ID_CARRIER      5'h0F
`define DRC_ID_RESTORE      5'h11
`define DRC_ID_WR_LOCK      5'h12
`define DRC_ID_TERM_A       5'h13
`define DRC_ID_ALT_ACCEL    5'h18
`define DRC_ID_ALT_DECEL    5'h19
`define DRC_PARAM_COUNT     26
// factory defaults
`define DRC_DEF_SETPOINT    16'h0000
`define DRC_DEF_MAX_FREQ    16'h1388
`define DRC_DEF_MIN_FREQ    16'h0000
`define DRC_LIM_MAX_FREQ    16'h9C40
`define DRC_DEF_RAMP_TIME   16'h0064
`define DRC_DEF_VF_MAX_V    16'h0ED8
`define DRC_DEF_VF_BASE_F   16'h1388
`define DRC_DEF_VF_MID_V    16'h00C8
`define DRC_DEF_VF_MID_F    16'h00FA
`define DRC_DEF_VF_MIN_V    16'h0096
`define DRC_DEF_VF_MIN_F    16'h007D
`define DRC_DEF_ONE         16'h0001
// setting codes
`define DRC_RESTORE_CODE    16'h0008
`define DRC_SRC_PANEL       16'h0000
`define DRC_SRC_TERM        16'h0001
`define DRC_SRC_SERIAL      16'h0002
`define DRC_FUNC_FWD        16'h0006
`define DRC_FUNC_REV        16'h0007
`define DRC_FUNC_STOP       16'h0009
`define DRC_FUNC_ALT_RAMP   16'h000A
`define DRC_CARRIER_MIN     16'h0001
`define DRC_CARRIER_MAX     16'h000F
// timing
`define DRC_CLK_PERIOD_NS   100
`define DRC_ENTER_HOLD_MS   2000
`define DRC_ENTER_HOLD_CYC  (`DRC_ENTER_HOLD_MS * 1000000 / `DRC_CLK_PERIOD_NS)
`define DRC_TIME_UNIT_NS    100000000
`define DRC_RAMP_UNIT_CYC   (`DRC_TIME_UNIT_NS / `DRC_CLK_PERIOD_NS)
`endif

//--- rtl/drc_pkg.sv
// types shared by the drive run-command / frequency control block
// assumes drc_map.svh carries every setting number except the carrier default, which is a drc_core parameter
package drc_pkg;
    // run states, one-hot
    typedef enum logic [2:0] {
        DRC_ST_STOP = 3'b001,
        DRC_ST_RUN  = 3'b010,
        DRC_ST_FLIP = 3'b100
    } drc_state_t;
    // parameter write request
    typedef struct packed {
        logic [4:0]  id;
        logic [15:0] data;
    } drc_pwr_t;
    // serial-link run command
    typedef struct packed {
        logic run;
        logic rev;
    } drc_ser_cmd_t;
    // target handed to the power stage
    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] volt;
        logic        rev;
        logic [3:0]  carrier;
    } drc_pwm_t;
endpackage

//--- rtl/drc_core.sv
// run-command decode, frequency clamp and ramp, v/f curve and parameter store
// assumes synchronous inputs on clk_sys (10 MHz); keys are one-cycle pulses except enter
// Behaviour
// - two-wire: fwd, rev, stop, both hold
// - terminal codes 6 fwd, 7 rev, 9 stop
// - three-wire self-hold only while stop active
// - three-wire pulse on then off latches start
// - opposite pulse replaces latched direction
// - releasing three-wire stop clears hold, decelerates
// - run source 2 takes serial link commands
// - stop-key lock default 1, applies after 2s enter
// - panel stop needs terminal release, reassert
// - reverse prevention default 1, 0 blocks reverse
// - output clamped to maximum frequency, default 50.00
// - below minimum frequency output minimum frequency
// - ramp times span zero to maximum frequency
// - primary ramp times, alternates via terminal
// - three-point v/f curve with given defaults
// - v/f minimum point defaults 1.25, 15
// - constant torque: voltage linear in frequency between curve points, flat above fundamental
// - carrier setting 1-15 drives power stage
// - writing 8 to restore loads factory defaults
// - lock set refuses init and changes
// - lock default 0, setpoint stays writable
// - run source 0 panel, 1 terminals, 2 serial
// - digital setpoint default 0.00, used for source 0
`timescale 1ns/1ps
`include "drc_map.svh"

module drc_core
    import drc_pkg::*;
#(
    parameter int          ENTER_HOLD_CYC  = `DRC_ENTER_HOLD_CYC,
    parameter int          RAMP_UNIT_CYC   = `DRC_RAMP_UNIT_CYC,
    parameter logic [15:0] CARRIER_DEFAULT = 16'h000A
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // operator panel
    input  wire logic         panel_run_key,
    input  wire logic         panel_rev_sel,
    input  wire logic         panel_stop_key,
    input  wire logic         panel_enter_key,
    // input terminals and external frequency
    input  wire logic [4:0]   term_in,
    input  wire logic [15:0]  ext_freq,
    // serial link
    input  wire logic         ser_cmd_valid,
    input  wire drc_ser_cmd_t ser_cmd,
    // parameter write port
    input  wire logic         param_wr,
    input  wire drc_pwr_t     param_req,
    output      logic         param_wr_done,
    output      logic         param_wr_refused,
    // status
    output      logic         running,
    output      logic         stop_key_active,
    // power stage target
    output      drc_pwm_t     pwm_target
);

    // released reset copy
    logic        rst_meta_n;                 // first stage, read only by second
    logic        rst_n;                      // synchronised reset
    // parameter store
    logic [15:0] param_mem [0:`DRC_PARAM_COUNT-1];
    // command state
    logic        cmd_run;                    // a run is requested
    logic        cmd_rev;                    // requested direction
    logic        term_inhibit;               // panel stop blocks terminal restart
    logic [4:0]  term_prev;                  // terminal levels last cycle
    logic        lock_eff;                   // stop key honoured
    logic [24:0] enter_cnt;                  // enter hold timer
    logic        load_defaults;              // factory load pending after reset
    // ramp
    drc_state_t  state;
    drc_state_t  next_state;
    logic [15:0] freq;
    logic [39:0] ramp_acc;

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // named views of the store
    wire [15:0] p_setpoint = param_mem[`DRC_ID_SETPOINT];
    wire [15:0] p_freq_src = param_mem[`DRC_ID_FREQ_SRC];
    wire [15:0] p_run_src  = param_mem[`DRC_ID_RUN_SRC];
    wire [15:0] p_max_f    = param_mem[`DRC_ID_MAX_FREQ];
    wire [15:0] p_min_f    = param_mem[`DRC_ID_MIN_FREQ];
    wire        rev_ok     = param_mem[`DRC_ID_REV_PREVENT][0];
    wire        wr_locked  = param_mem[`DRC_ID_WR_LOCK] == `DRC_DEF_ONE;

    // terminal function decode
    logic [4:0] is_fwd, is_rev, is_stop, is_alt;
    for (genvar t = 0; t < 5; t++) begin : g_term
        wire [15:0] fn = param_mem[`DRC_ID_TERM_A + t];
        assign is_fwd[t]  = fn == `DRC_FUNC_FWD;
        assign is_rev[t]  = fn == `DRC_FUNC_REV;
        assign is_stop[t] = fn == `DRC_FUNC_STOP;
        assign is_alt[t]  = fn == `DRC_FUNC_ALT_RAMP;
    end
    wire t_fwd      = |(is_fwd & term_in);
    wire t_rev      = |(is_rev & term_in);
    wire t_stop     = |(is_stop & term_in);
    wire t_fwd_fall = |(is_fwd & term_prev & ~term_in);
    wire t_rev_fall = |(is_rev & term_prev & ~term_in);
    wire three_wire = |is_stop;
    wire alt_ramp   = |(is_alt & term_in);
    wire src_panel  = p_run_src == `DRC_SRC_PANEL;
    wire src_term   = p_run_src == `DRC_SRC_TERM;
    wire src_ser    = p_run_src == `DRC_SRC_SERIAL;
    wire stop_hit   = panel_stop_key && lock_eff;

    // parameter write acceptance; lock itself must stay writable to be cleared
    wire id_ok      = param_req.id < 5'(`DRC_PARAM_COUNT);
    wire exempt     = param_req.id == `DRC_ID_SETPOINT || param_req.id == `DRC_ID_WR_LOCK;
    wire wr_ok      = param_wr && id_ok && (!wr_locked || exempt);
    wire do_restore = wr_ok && param_req.id == `DRC_ID_RESTORE
                      && param_req.data == `DRC_RESTORE_CODE;

    // factory value of every entry
    function automatic logic [15:0] factory(input int i);
        case (i)
            `DRC_ID_SETPOINT:    factory = `DRC_DEF_SETPOINT;
            `DRC_ID_STOP_LOCK:   factory = `DRC_DEF_ONE;
            `DRC_ID_REV_PREVENT: factory = `DRC_DEF_ONE;
            `DRC_ID_MAX_FREQ:    factory = `DRC_DEF_MAX_FREQ;
            `DRC_ID_MIN_FREQ:    factory = `DRC_DEF_MIN_FREQ;
            `DRC_ID_ACCEL,
            `DRC_ID_DECEL,
            `DRC_ID_ALT_ACCEL,
            `DRC_ID_ALT_DECEL:   factory = `DRC_DEF_RAMP_TIME;
            `DRC_ID_VF_MAX_V:    factory = `DRC_DEF_VF_MAX_V;
            `DRC_ID_VF_BASE_F:   factory = `DRC_DEF_VF_BASE_F;
            `DRC_ID_VF_MID_V:    factory = `DRC_DEF_VF_MID_V;
            `DRC_ID_VF_MID_F:    factory = `DRC_DEF_VF_MID_F;
            `DRC_ID_VF_MIN_V:    factory = `DRC_DEF_VF_MIN_V;
            `DRC_ID_VF_MIN_F:    factory = `DRC_DEF_VF_MIN_F;
            `DRC_ID_CARRIER:     factory = CARRIER_DEFAULT;
            `DRC_ID_TERM_A:      factory = `DRC_FUNC_FWD;
            `DRC_ID_TERM_A + 1:  factory = `DRC_FUNC_REV;
            default:             factory = 16'h0000;
        endcase
    endfunction

    // parameter store; restore leaves the restore entry at 0 again
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `DRC_PARAM_COUNT; i++) begin
                param_mem[i] <= 16'h0000;
            end
        end else if (load_defaults || do_restore) begin
            for (int i = 0; i < `DRC_PARAM_COUNT; i++) begin
                param_mem[i] <= factory(i);
            end
        end else if (wr_ok) begin
            param_mem[param_req.id] <= param_req.data;
        end
    end

    // write answer one cycle after the request; defaults load once after reset,
    // so the first synchroniser stage is read by nothing but the second
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            param_wr_done    <= 1'b0;
            param_wr_refused <= 1'b0;
            load_defaults    <= 1'b1;
        end else begin
            load_defaults    <= 1'b0;
            param_wr_done    <= wr_ok;
            param_wr_refused <= param_wr && !wr_ok;
        end
    end

    // stop-key lock only takes the stored value after enter is held
    wire enter_done = enter_cnt == 25'(ENTER_HOLD_CYC - 1);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            enter_cnt <= 25'h0000000;
            lock_eff  <= 1'b1;
        end else if (!panel_enter_key) begin
            enter_cnt <= 25'h0000000;
        end else if (enter_done) begin
            lock_eff  <= param_mem[`DRC_ID_STOP_LOCK][0];
        end else begin
            enter_cnt <= enter_cnt + 25'h0000001;
        end
    end

    // run command decode per source
    logic next_run, next_rev, next_inhibit;
    always_comb begin
        next_run     = cmd_run;
        next_rev     = cmd_rev;
        next_inhibit = term_inhibit;
        if (src_panel) begin
            next_inhibit = 1'b0;
            if (panel_run_key) begin
                next_run = 1'b1;
                next_rev = panel_rev_sel && rev_ok;
            end
        end else if (src_ser) begin
            next_inhibit = 1'b0;
            if (ser_cmd_valid) begin
                next_run = ser_cmd.run;
                next_rev = ser_cmd.rev && rev_ok;
            end
        end else if (src_term && three_wire) begin
            if (!t_fwd && !t_rev) begin
                next_inhibit = 1'b0;
            end
            if (!t_stop) begin
                next_run = 1'b0;
            end else if (term_inhibit) begin
                next_run = 1'b0;
            end else if (t_rev_fall && rev_ok) begin
                next_run = 1'b1;
                next_rev = 1'b1;
            end else if (t_fwd_fall) begin
                next_run = 1'b1;
                next_rev = 1'b0;
            end
        end else if (src_term) begin
            if (term_inhibit) begin
                next_run     = 1'b0;
                next_inhibit = t_fwd || t_rev;
            end else if (t_fwd && !t_rev) begin
                next_run = 1'b1;
                next_rev = 1'b0;
            end else if (t_rev && !t_fwd) begin
                next_run = rev_ok;
                next_rev = rev_ok;
            end else if (!t_fwd && !t_rev) begin
                next_run = 1'b0;
            end
        end else begin
            next_run     = 1'b0;
            next_inhibit = 1'b0;
        end
        if (stop_hit) begin
            next_run     = 1'b0;
            next_inhibit = src_term;
        end
    end

    // command registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmd_run      <= 1'b0;
            cmd_rev      <= 1'b0;
            term_inhibit <= 1'b0;
            term_prev    <= 5'h00;
        end else begin
            cmd_run      <= next_run;
            cmd_rev      <= next_rev;
            term_inhibit <= next_inhibit;
            term_prev    <= term_in;
        end
    end

    // setpoint selection and clamp
    wire [15:0] raw_sp  = (p_freq_src == 16'h0000) ? p_setpoint : ext_freq;
    wire [15:0] max_c   = (p_max_f > `DRC_LIM_MAX_FREQ) ? `DRC_LIM_MAX_FREQ : p_max_f;
    wire [15:0] hi_sp   = (raw_sp > max_c) ? max_c : raw_sp;
    wire [15:0] clamped = (hi_sp < p_min_f) ? p_min_f : hi_sp;

    // run state: a direction change ramps through zero first
    wire at_zero = freq == 16'h0000;
    always_comb begin
        next_state = state;
        case (state)
            DRC_ST_STOP: if (cmd_run) begin
                next_state = DRC_ST_RUN;
            end
            DRC_ST_RUN: if (!cmd_run && at_zero) begin
                next_state = DRC_ST_STOP;
            end else if (cmd_run && cmd_rev != pwm_target.rev) begin
                next_state = DRC_ST_FLIP;
            end
            DRC_ST_FLIP: if (at_zero) begin
                next_state = cmd_run ? DRC_ST_RUN : DRC_ST_STOP;
            end
            default: next_state = DRC_ST_STOP;
        endcase
    end
    wire [15:0] goal = (state == DRC_ST_RUN && cmd_run) ? clamped : 16'h0000;

    // ramp slope: max frequency per selected time
    wire        up      = goal > freq;
    wire        down    = goal < freq;
    wire [15:0] t_acc   = param_mem[alt_ramp ? `DRC_ID_ALT_ACCEL : `DRC_ID_ACCEL];
    wire [15:0] t_dec   = param_mem[alt_ramp ? `DRC_ID_ALT_DECEL : `DRC_ID_DECEL];
    wire [15:0] t_sel   = up ? t_acc : t_dec;
    wire [15:0] t_use   = (t_sel == 16'h0000) ? 16'h0001 : t_sel;
    wire [39:0] limit   = 40'(t_use) * 40'(RAMP_UNIT_CYC);
    wire [39:0] acc_sum = ramp_acc + 40'(max_c);
    wire        step    = acc_sum >= limit;

    // frequency ramp; one 0.01 Hz step at most per cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state    <= DRC_ST_STOP;
            freq     <= 16'h0000;
            ramp_acc <= 40'h0000000000;
        end else begin
            state <= next_state;
            if (!up && !down) begin
                ramp_acc <= 40'h0000000000;
            end else if (step) begin
                ramp_acc <= acc_sum - limit;
                freq     <= up ? freq + 16'h0001 : freq - 16'h0001;
            end else begin
                ramp_acc <= acc_sum;
            end
        end
    end

    // linear interpolation between two curve points
    function automatic logic [15:0] interp(input logic [15:0] f, input logic [15:0] f0,
                                           input logic [15:0] f1, input logic [15:0] v0,
                                           input logic [15:0] v1);
        logic [31:0] num;
        num = 32'h00000000;
        if (f1 <= f0 || v1 < v0) begin
            interp = v1;
        end else begin
            num    = 32'(f - f0) * 32'(v1 - v0);
            interp = v0 + 16'(num / 32'(f1 - f0));
        end
    endfunction

    // v/f curve: origin, minimum, intermediate, fundamental, then flat
    wire [15:0] fmin = param_mem[`DRC_ID_VF_MIN_F];
    wire [15:0] fmid = param_mem[`DRC_ID_VF_MID_F];
    wire [15:0] fb   = param_mem[`DRC_ID_VF_BASE_F];
    wire [15:0] vmin = param_mem[`DRC_ID_VF_MIN_V];
    wire [15:0] vmid = param_mem[`DRC_ID_VF_MID_V];
    wire [15:0] vmax = param_mem[`DRC_ID_VF_MAX_V];
    wire [15:0] volt = (freq >= fb)   ? vmax :
                       (freq >= fmid) ? interp(freq, fmid, fb, vmid, vmax) :
                       (freq >= fmin) ? interp(freq, fmin, fmid, vmin, vmid) :
                       interp(freq, 16'h0000, fmin, 16'h0000, vmin);

    // carrier kept inside its range
    wire [15:0] car_raw = param_mem[`DRC_ID_CARRIER];
    wire [15:0] car     = (car_raw < `DRC_CARRIER_MIN) ? `DRC_CARRIER_MIN :
                          (car_raw > `DRC_CARRIER_MAX) ? `DRC_CARRIER_MAX : car_raw;

    // registered outputs; direction only changes at standstill
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pwm_target      <= '0;
            running         <= 1'b0;
            stop_key_active <= 1'b1;
        end else begin
            pwm_target.freq    <= freq;
            pwm_target.volt    <= volt;
            pwm_target.carrier <= car[3:0];
            if (at_zero && next_state != DRC_ST_STOP) begin
                pwm_target.rev <= cmd_rev;
            end
            running         <= state != DRC_ST_STOP;
            stop_key_active <= lock_eff;
        end
    end

endmodule // drc_core

//--- sim/drc_core_sva.sv
// checker for the drive core: write answers, frequency ramp, direction, stop key
// assumes one clock domain; bound to the core from the bench top
`timescale 1ns/1ps
module drc_core_sva
    import drc_pkg::*;
(
    // clock and reset
    input wire logic     clk_sys,
    input wire logic     rstn,
    // keys
    input wire logic     panel_stop_key,
    input wire logic     panel_enter_key,
    // parameter port
    input wire logic     param_wr,
    input wire drc_pwr_t param_req,
    input wire logic     param_wr_done,
    input wire logic     param_wr_refused,
    // status and target
    input wire logic     running,
    input wire logic     stop_key_active,
    input wire drc_pwm_t pwm_target
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_wr_answer: assert property (param_wr |=> param_wr_done != param_wr_refused)
        else $error("write got no single answer");
    a_wr_quiet: assert property (!param_wr |=> !param_wr_done && !param_wr_refused)
        else $error("answer without write");
    a_bad_id: assert property (param_wr && param_req.id >= 5'h1A |=> param_wr_refused)
        else $error("unknown index accepted");
    a_setpoint_open: assert property (param_wr && param_req.id == 5'h00 |=> param_wr_done)
        else $error("setpoint write refused");
    a_freq_ceiling: assert property (pwm_target.freq <= 16'h9C40)
        else $error("frequency above ceiling");
    a_step_one: assert property ($changed(pwm_target.freq) |->
        (pwm_target.freq - $past(pwm_target.freq) == 16'h0001) ||
        ($past(pwm_target.freq) - pwm_target.freq == 16'h0001))
        else $error("frequency jumped");
    a_rev_at_zero: assert property ($changed(pwm_target.rev) |->
        pwm_target.freq == 16'h0000 || $past(pwm_target.freq) == 16'h0000)
        else $error("direction flipped while turning");
    a_stop_halts: assert property (panel_stop_key && stop_key_active |->
        ##3 pwm_target.freq <= $past(pwm_target.freq))
        else $error("stop key did not stop");
    a_lock_enter: assert property ($changed(stop_key_active) |-> $past(panel_enter_key))
        else $error("stop lock changed without enter");
    a_carrier_set: assert property (running |-> pwm_target.carrier != 4'h0)
        else $error("running with no carrier");
endmodule // drc_core_sva

//--- sim/drc_ext_model.sv
// keypad, switch contacts and serial host facing the drive core
// assumes the bench calls its tasks; every change lands on a falling edge
`timescale 1ns/1ps
module drc_ext_model
    import drc_pkg::*;
(
    input  wire logic         clk_sys,    // system clock
    output      logic [4:0]   term_in,    // contact levels
    output      logic         stop_key,   // panel stop, one-cycle pulse
    output      logic         enter_key,  // panel enter, level
    output      logic         ser_valid,  // serial strobe
    output      drc_ser_cmd_t ser_cmd     // serial run command
);
    initial begin
        term_in = 5'h00;
        {stop_key, enter_key, ser_valid} = 3'h0;
        ser_cmd = '0;
    end
    // contact held at a level until changed again
    task automatic hold(input int b, input logic v);
        @(negedge clk_sys);
        term_in[b] = v;
    endtask
    // on, then off: a three-wire start or direction change
    task automatic pulse(input int b);
        hold(b, 1'b1);
        hold(b, 1'b0);
    endtask
    // stop key pressed for one cycle
    task automatic stop_press();
        @(negedge clk_sys);
        stop_key = 1'b1;
        @(negedge clk_sys);
        stop_key = 1'b0;
    endtask
    // enter held longer than the (shortened) hold time
    task automatic enter_hold();
        @(negedge clk_sys);
        enter_key = 1'b1;
        repeat (20) @(negedge clk_sys);
        enter_key = 1'b0;
    endtask
    // one serial command; the strobe stands one cycle
    task automatic send(input logic run, input logic rev);
        @(negedge clk_sys);
        ser_valid = 1'b1;
        ser_cmd.run = run;
        ser_cmd.rev = rev;
        @(negedge clk_sys);
        ser_valid = 1'b0;
    endtask
endmodule // drc_ext_model

//--- sim/test_drive_run_command_frequency_control.sv
// bench for the drive core: run sources, clamps, locks, three-wire and stop key
// assumes ramp unit and enter hold shortened; setpoint 2.00 Hz mostly
`timescale 1ns/1ps
module test_drive_run_command_frequency_control;
    import drc_pkg::*;
    logic         clk_sys = 1'b0;
    logic         rstn = 1'b0;
    logic         param_wr = 1'b0;
    drc_pwr_t     param_req = '0;
    logic [4:0]   term_in;
    logic         stop_key, enter_key, ser_valid, done, refused, running, stop_key_active;
    drc_ser_cmd_t ser_cmd;
    drc_pwm_t     pwm_target;
    logic         run_key = 1'b0, rev_sel = 1'b0;
    logic [15:0]  ext_f = 16'h0000;
    int           num_errors = 0;
    int           n_compared = 0;
    int           cycles = 0;
    always #50 clk_sys = ~clk_sys;
    drc_ext_model ext (.clk_sys(clk_sys), .term_in(term_in), .stop_key(stop_key),
        .enter_key(enter_key), .ser_valid(ser_valid), .ser_cmd(ser_cmd));
    // panel run key, its direction and the external frequency come from the bench
    drc_core #(.ENTER_HOLD_CYC(16), .RAMP_UNIT_CYC(100)) dut (.clk_sys(clk_sys),
        .rstn(rstn), .panel_run_key(run_key), .panel_rev_sel(rev_sel),
        .panel_stop_key(stop_key), .panel_enter_key(enter_key), .term_in(term_in),
        .ext_freq(ext_f),
        .ser_cmd_valid(ser_valid), .ser_cmd(ser_cmd), .param_wr(param_wr),
        .param_req(param_req), .param_wr_done(done), .param_wr_refused(refused),
        .running(running), .stop_key_active(stop_key_active), .pwm_target(pwm_target));
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard: the whole run needs well under this
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one write; answer pulse is sampled in the cycle it stands
    task automatic wr(input logic [4:0] id, input logic [15:0] d, input logic ok);
        @(negedge clk_sys);
        param_wr = 1'b1;
        param_req.id = id;
        param_req.data = d;
        @(negedge clk_sys);
        chk({done, refused}, {ok, !ok}, "write answer");
        param_wr = 1'b0;
    endtask
    // panel run key pressed for one cycle with a direction
    task automatic run_press(input logic r);
        @(negedge clk_sys);
        run_key = 1'b1;
        rev_sel = r;
        @(negedge clk_sys);
        run_key = 1'b0;
    endtask
    // let a command land, then wait for the ramp to settle
    task automatic wf(input logic [15:0] f, input logic r);
        repeat (8) @(negedge clk_sys);
        for (int i = 0; i < 3000 && pwm_target.freq !== f; i++) @(negedge clk_sys);
        repeat (2) @(negedge clk_sys); // running settles a cycle behind the frequency
        chk(pwm_target.freq, f, "freq");
        chk(pwm_target.rev, r, "dir");
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(stop_key_active, 1, "stop lock");
        wr(5'h02, 16'h0001, 1);
        chk(pwm_target.carrier, 16'h000A, "carrier");
        wr(5'h00, 16'h00C8, 1);
        ext.hold(0, 1);
        wf(16'h00C8, 0);
        chk(pwm_target.volt, 16'h00B4, "volt");
        ext.hold(1, 1);
        wf(16'h00C8, 0);
        ext.hold(0, 0);
        wf(16'h00C8, 1);
        ext.hold(1, 0);
        wf(16'h0000, 1);
        $display("two-wire test done");
        ext.hold(0, 1);
        wf(16'h00C8, 0);
        ext.stop_press();
        wf(16'h0000, 0);
        chk(running, 0, "stays stopped");
        ext.hold(0, 0);
        ext.hold(0, 1);
        wf(16'h00C8, 0);
        wr(5'h03, 16'h0000, 1);
        chk(stop_key_active, 1, "lock waits enter");
        ext.enter_hold();
        chk(stop_key_active, 0, "lock applied");
        ext.stop_press();
        wf(16'h00C8, 0);
        wr(5'h03, 16'h0001, 1);
        ext.enter_hold();
        ext.hold(0, 0);
        wf(16'h0000, 0);
        $display("stop key test done");
        wr(5'h04, 16'h0000, 1);
        ext.hold(1, 1);
        wf(16'h0000, 0);
        chk(running, 0, "reverse blocked");
        ext.hold(1, 0);
        wr(5'h04, 16'h0001, 1);
        wr(5'h02, 16'h0002, 1);
        ext.send(1, 1);
        wf(16'h00C8, 1);
        ext.send(0, 0);
        wf(16'h0000, 1);
        wr(5'h02, 16'h0000, 1);
        wr(5'h01, 16'h0001, 1);
        ext_f = 16'h0064;
        run_press(1);
        wf(16'h0064, 1);
        ext.stop_press();
        wf(16'h0000, 1);
        chk(running, 0, "panel stop");
        wr(5'h01, 16'h0000, 1);
        wr(5'h02, 16'h0001, 1);
        $display("source test done");
        wr(5'h06, 16'h012C, 1);
        ext.hold(0, 1);
        wf(16'h012C, 0);
        ext.hold(0, 0);
        wf(16'h0000, 0);
        wr(5'h06, 16'h0000, 1);
        wr(5'h07, 16'h0001, 1);
        wr(5'h08, 16'h0001, 1);
        wr(5'h05, 16'h0096, 1);
        ext.hold(0, 1);
        wf(16'h0096, 0);
        ext.hold(0, 0);
        wf(16'h0000, 0);
        $display("clamp test done");
        wr(5'h12, 16'h0001, 1);
        wr(5'h05, 16'h1388, 0);
        wr(5'h00, 16'h00C8, 1);
        wr(5'h11, 16'h0008, 0);
        wr(5'h1F, 16'h0000, 0);
        wr(5'h12, 16'h0000, 1);
        wr(5'h11, 16'h0008, 1);
        wr(5'h02, 16'h0001, 1);
        wr(5'h00, 16'h012C, 1);
        ext.hold(0, 1);
        wf(16'h012C, 0);
        ext.hold(0, 0);
        wf(16'h0000, 0);
        $display("lock test done");
        wr(5'h15, 16'h0009, 1);
        ext.pulse(0);
        wf(16'h0000, 0);
        ext.hold(2, 1);
        ext.pulse(0);
        wf(16'h012C, 0);
        ext.pulse(1);
        wf(16'h012C, 1);
        ext.hold(2, 0);
        wf(16'h0000, 1);
        chk(running, 0, "three-wire stop");
        $display("three-wire test done");
        end_sim();
    end
endmodule // test_drive_run_command_frequency_control
bind drc_core drc_core_sva sva_i (.clk_sys(clk_sys), .rstn(rstn),
    .panel_stop_key(panel_stop_key), .panel_enter_key(panel_enter_key),
    .param_wr(param_wr), .param_req(param_req), .param_wr_done(param_wr_done),
    .param_wr_refused(param_wr_refused), .running(running),
    .stop_key_active(stop_key_active), .pwm_target(pwm_target));
